// ### conv_ctrl_defs.vh
// Purpose: constants for the converter gain, reference and clock control
// Assumes: one system clock at 20 MHz, asynchronous active-low reset
// Notes: encodings of gain, input-select and reference fields live here
`ifndef CONV_CTRL_DEFS_VH
`define CONV_CTRL_DEFS_VH
`define GAIN_W 3
`define GAIN_X4 3'h2
`define MUX_W 4
`define MUX_SUPPLY_LO 4'h8
`define MUX_SUPPLY_HI 4'hB
`define REF_W 2
`define REF_INTERNAL 2'h0
`define REF_EXTERNAL 2'h1
`define REF_SUPPLY 2'h2
`define REF_SETTLE_NS 25000
`define CLOCK_NS 50
`define REF_SETTLE_CYC ((`REF_SETTLE_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define CLK_HZ 20000000
`define OSC_NORMAL_HZ 1024000
`define OSC_FAST_HZ 2048000
`define MOD_DIV 4
`define ACC_W 16
`endif

// ### sample_fifo.v
// Purpose: small first-in first-out buffer for converter results
// Assumes: one clock, storage in flip-flops
// Notes: honest full and empty, ready drops when full
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire rst_b,
  input wire clk_en,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage words
  reg [AW-1:0] wr_q; // write index
  reg [AW-1:0] rd_q; // read index
  reg [AW:0] cnt_q; // fill level
  wire push;
  wire pop;
  integer i;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  ////////////////////////////////////////////////////////////////
  // pointer and level update
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else if (clk_en) begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### adc_gain_ref_clock_control.v
// Purpose: amplifier bypass, gain clamp, reference select, modulator clock, decimator
// Assumes: 20 MHz system clock; modulator bit arrives from the analog core
// Notes: oscillator is modelled by a phase accumulator on the system clock
`timescale 1ns/1ps
`include "conv_ctrl_defs.vh"
module adc_gain_ref_clock_control #(
  parameter DECIM = 64,
  parameter DW = 16,
  parameter FIFO_DEPTH = 8,
  parameter REF_SETTLE = `REF_SETTLE_CYC
) (
  input wire clock,
  input wire rst_b,
  input wire clk_en,
  input wire [`GAIN_W-1:0] gain_field,
  input wire amp_skip_bit,
  input wire [`MUX_W-1:0] input_select_field,
  input wire [`REF_W-1:0] ref_source_field,
  input wire ref_load,
  input wire fast_mode,
  input wire mod_bit,
  output reg amp_enable,
  output reg [`GAIN_W-1:0] eff_gain,
  output reg [1:0] cap_gain_sel,
  output reg [2:0] amp_gain_sel,
  output reg [`REF_W-1:0] ref_select,
  output reg ext_ref_buf_en,
  output reg ref_settling,
  output reg osc_tick,
  output reg mod_tick,
  output wire sample_valid,
  input wire sample_ready,
  output wire [DW-1:0] sample_data,
  output wire overrun
);
  ////////////////////////////////////////////////////////////////
  // helpers
  // supply-referenced input codes
  function is_supply_ref;
    input [`MUX_W-1:0] m;
    begin
      is_supply_ref = (m >= `MUX_SUPPLY_LO) && (m <= `MUX_SUPPLY_HI);
    end
  endfunction
  // low gains need no amplifier
  function is_low_gain;
    input [`GAIN_W-1:0] g;
    begin
      is_low_gain = (g <= `GAIN_X4);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // input synchroniser for the modulator bit from the analog side
  reg mod_s1_q; // first stage
  reg mod_s2_q; // second stage
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mod_s1_q <= 1'b0;
      mod_s2_q <= 1'b0;
    end else if (clk_en) begin
      mod_s1_q <= mod_bit;
      mod_s2_q <= mod_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // gain path and amplifier bypass
  reg amp_en_d;
  reg [`GAIN_W-1:0] gain_d;
  reg supply_ref;
  always @* begin
    supply_ref = is_supply_ref(input_select_field);
    gain_d = gain_field;
    amp_en_d = 1'b1;
    if (supply_ref) begin
      amp_en_d = 1'b0;
      if (!is_low_gain(gain_field)) begin
        gain_d = `GAIN_X4;
      end
    end else if (is_low_gain(gain_field)) begin
      amp_en_d = !amp_skip_bit;
    end else begin
      amp_en_d = 1'b1;
    end
  end

  // registered gain outputs: capacitor stage and amplifier stage split
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      amp_enable <= 1'b1;
      eff_gain <= {`GAIN_W{1'b0}};
      cap_gain_sel <= 2'h0;
      amp_gain_sel <= 3'h0;
    end else if (clk_en) begin
      amp_enable <= amp_en_d;
      eff_gain <= gain_d;
      if (is_low_gain(gain_d)) begin
        cap_gain_sel <= gain_d[1:0];
        amp_gain_sel <= 3'h0;
      end else begin
        cap_gain_sel <= 2'h2; // capacitor stage at four
        amp_gain_sel <= gain_d - `GAIN_X4;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // reference selection and settling indication
  reg [15:0] settle_q; // settle countdown
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ref_select <= `REF_INTERNAL;
      ext_ref_buf_en <= 1'b0;
      settle_q <= REF_SETTLE[15:0];
      ref_settling <= 1'b1;
    end else if (clk_en) begin
      if (ref_load) begin
        ref_select <= (ref_source_field == 2'h3) ? `REF_SUPPLY : ref_source_field;
        ext_ref_buf_en <= (ref_source_field == `REF_EXTERNAL);
        // external or supply to internal restarts settling
        if (ref_source_field == `REF_INTERNAL && ref_select != `REF_INTERNAL) begin
          settle_q <= REF_SETTLE[15:0];
          ref_settling <= 1'b1;
        end
      end else if (settle_q != 16'h0) begin
        settle_q <= settle_q - 16'h1;
        ref_settling <= (settle_q != 16'h1);
      end else begin
        ref_settling <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // oscillator model: phase accumulator, step by mode
  // wide step values, cut to the accumulator width on purpose
  localparam [63:0] STEP_N_W = (`OSC_NORMAL_HZ * 64'd65536) / `CLK_HZ;
  localparam [63:0] STEP_F_W = (`OSC_FAST_HZ * 64'd65536) / `CLK_HZ;
  localparam [`ACC_W-1:0] STEP_N = STEP_N_W[`ACC_W-1:0];
  localparam [`ACC_W-1:0] STEP_F = STEP_F_W[`ACC_W-1:0];
  reg [`ACC_W-1:0] phase_q; // oscillator phase
  reg [1:0] div_q; // divide by four
  wire [`ACC_W:0] phase_sum;
  assign phase_sum = {1'b0, phase_q} + {1'b0, (fast_mode ? STEP_F : STEP_N)};
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= {`ACC_W{1'b0}};
      div_q <= 2'h0;
      osc_tick <= 1'b0;
      mod_tick <= 1'b0;
    end else if (clk_en) begin
      phase_q <= phase_sum[`ACC_W-1:0];
      osc_tick <= phase_sum[`ACC_W];
      mod_tick <= 1'b0;
      if (phase_sum[`ACC_W]) begin
        div_q <= div_q + 2'h1;
        mod_tick <= (div_q == `MOD_DIV - 1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // decimating FIR: boxcar over DECIM modulator bits, counted in mod ticks
  localparam ST_RUN = 2'b01;
  localparam ST_DUMP = 2'b10;
  reg [1:0] st_q; // one-hot state
  reg [15:0] tap_q; // bits seen this conversion
  reg [DW-1:0] acc_q; // running sum
  reg [DW-1:0] res_q; // finished result
  reg res_v_q; // result waiting for fifo
  reg ovr_q; // result dropped
  wire fifo_ready;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_RUN;
      tap_q <= 16'h0;
      acc_q <= {DW{1'b0}};
      res_q <= {DW{1'b0}};
      res_v_q <= 1'b0;
      ovr_q <= 1'b0;
    end else if (clk_en) begin
      if (res_v_q && fifo_ready) begin
        res_v_q <= 1'b0;
      end
      case (st_q)
        ST_RUN: begin
          // steps at mod rate, so rate scales with oscillator
          if (mod_tick) begin
            acc_q <= acc_q + {{(DW-1){1'b0}}, mod_s2_q};
            tap_q <= tap_q + 16'h1;
            if (tap_q == DECIM[15:0] - 16'h1) begin
              st_q <= ST_DUMP;
            end
          end
        end
        ST_DUMP: begin
          // fresh sum each conversion settles in one cycle
          res_q <= acc_q;
          if (res_v_q && !fifo_ready) begin
            ovr_q <= 1'b1;
          end
          res_v_q <= 1'b1;
          acc_q <= {DW{1'b0}};
          tap_q <= 16'h0;
          st_q <= ST_RUN;
        end
        default: begin
          st_q <= ST_RUN;
        end
      endcase
    end
  end
  assign overrun = ovr_q;

  ////////////////////////////////////////////////////////////////
  // result buffer
  sample_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(res_v_q),
    .in_ready(fifo_ready),
    .in_data(res_q),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(sample_data)
  );
endmodule

// ### conv_ctrl_chk.sv
// Purpose: port assertions for the converter control block
// Assumes: one clock, reset asynchronous and active low
// Notes: bound into the top module at the foot of this file
`timescale 1ns/1ps
`include "conv_ctrl_defs.vh"
module conv_ctrl_chk (
  input wire clock,
  input wire rst_b,
  input wire [`GAIN_W-1:0] gain_field,
  input wire amp_skip_bit,
  input wire [`MUX_W-1:0] input_select_field,
  input wire [`REF_W-1:0] ref_source_field,
  input wire ref_load,
  input wire fast_mode,
  input wire amp_enable,
  input wire [`GAIN_W-1:0] eff_gain,
  input wire [2:0] amp_gain_sel,
  input wire [`REF_W-1:0] ref_select,
  input wire ref_settling,
  input wire osc_tick,
  input wire mod_tick
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // high for the supply-referenced input codes
  wire sup = input_select_field >= `MUX_SUPPLY_LO && input_select_field <= `MUX_SUPPLY_HI;
  reg [2:0] osc_cnt_q; // oscillator ticks since the last modulator tick
  ////////////////////////////////////////////////////////////////
  // count oscillator ticks, restart on each modulator tick
  always @(posedge clock or negedge rst_b)
    if (!rst_b) osc_cnt_q <= 3'h0;
    else osc_cnt_q <= mod_tick ? 3'h0 : osc_cnt_q + {2'h0, osc_tick};
  // settle window held high
  sequence settle_run;
    ref_settling [*8];
  endsequence
  ////////////////////////////////////////////////////////////////
  skip_low_a: assert property (!sup && amp_skip_bit && gain_field <= 3'h2 |=> !amp_enable)
    else $error("amplifier not bypassed by skip bit");
  supply_off_a: assert property (sup |=> !amp_enable)
    else $error("amplifier on for supply input");
  gain_clamp_a: assert property (sup && gain_field > 3'h2 |=> eff_gain == 3'h2)
    else $error("gain not clamped to four");
  high_gain_a: assert property (!sup && gain_field > 3'h2 |=> amp_enable && eff_gain == $past(gain_field)
    && amp_gain_sel == $past(gain_field) - 3'h2) else $error("high gain path wrong");
  ref_map_a: assert property (ref_load |=> ref_select ==
    ($past(ref_source_field) == 2'h3 ? 2'h2 : $past(ref_source_field))) else $error("reference select wrong");
  ref_reset_a: assert property ($rose(rst_b) |-> ref_select == `REF_INTERNAL && ref_settling)
    else $error("reference reset state wrong");
  settle_len_a: assert property (ref_load && ref_source_field == `REF_INTERNAL
    && ref_select != `REF_INTERNAL |=> settle_run ##[1:4] !ref_settling) else $error("settle window wrong");
  osc_norm_a: assert property (osc_tick && !fast_mode |=> ##8 !osc_tick [*8])
    else $error("normal oscillator too fast");
  osc_gap_a: assert property (osc_tick |-> ##[1:20] osc_tick)
    else $error("oscillator tick missing");
  mod_quarter_a: assert property (mod_tick |-> osc_cnt_q + {2'h0, osc_tick} == 3'h4)
    else $error("modulator tick not every fourth");
endmodule
bind adc_gain_ref_clock_control conv_ctrl_chk chk (.clock(clock), .rst_b(rst_b), .gain_field(gain_field),
  .amp_skip_bit(amp_skip_bit), .input_select_field(input_select_field), .ref_source_field(ref_source_field),
  .ref_load(ref_load), .fast_mode(fast_mode), .amp_enable(amp_enable), .eff_gain(eff_gain),
  .amp_gain_sel(amp_gain_sel), .ref_select(ref_select), .ref_settling(ref_settling), .osc_tick(osc_tick),
  .mod_tick(mod_tick));

// ### testbench.sv
// Purpose: self-checking bench for the converter control block
// Assumes: 20 MHz clock, short settle and decimation counts
// Notes: modulator bit held high so each result equals the decimation count
`timescale 1ns/1ps
`include "conv_ctrl_defs.vh"
module testbench;
  localparam DECIM = 8;
  reg clock = 1'b0, rst_b = 1'b0, skip = 1'b0, ref_load = 1'b0, fast = 1'b0, rdy = 1'b0, sup;
  reg [2:0] gain = 3'h0, e;
  reg [3:0] mux = 4'h0;
  reg [1:0] rsrc = 2'h0;
  wire amp_en, ext_buf, settling, osc_t, mod_t, s_valid, ovr;
  wire [2:0] eff, amp_sel;
  wire [1:0] cap_sel, ref_sel;
  wire [15:0] s_data;
  integer mismatches = 0, checks = 0, cyc = 0, i, n, m;
  always #25 clock = ~clock;
  adc_gain_ref_clock_control #(.DECIM(DECIM), .REF_SETTLE(10)) dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1),
    .gain_field(gain), .amp_skip_bit(skip), .input_select_field(mux), .ref_source_field(rsrc), .ref_load(ref_load),
    .fast_mode(fast), .mod_bit(1'b1), .amp_enable(amp_en), .eff_gain(eff), .cap_gain_sel(cap_sel),
    .amp_gain_sel(amp_sel), .ref_select(ref_sel), .ext_ref_buf_en(ext_buf), .ref_settling(settling),
    .osc_tick(osc_t), .mod_tick(mod_t), .sample_valid(s_valid), .sample_ready(rdy), .sample_data(s_data),
    .overrun(ovr));
  ////////////////////////////////////////////////////////////////
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // reset with a chosen operating mode
  task restart(input f);
    begin
      @(posedge clock);
      rst_b <= 1'b0;
      fast <= f;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
    end
  endtask
  // clock cycles spanned by 16 modulator ticks
  task rate(input f, input integer exp);
    begin
      restart(f);
      n = 0;
      while (!mod_t) @(posedge clock);
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge clock);
        n = n + 1;
        while (!mod_t) begin
          @(posedge clock);
          n = n + 1;
        end
      end
      chk(n + 8 >= exp && n <= exp + 8, 1);
      $display("rate test done, %0d cycles", n);
    end
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    for (m = 7; m < 13; m = m + 1)
      for (n = 0; n < 16; n = n + 1) begin
        @(posedge clock);
        mux <= m[3:0];
        gain <= n[2:0];
        skip <= n[3];
        @(posedge clock);
        #1;
        sup = m >= 8 && m <= 11;
        e = (sup && n[2:0] > 2) ? 3'h2 : n[2:0];
        chk(amp_en, !(sup || (n[3] && n[2:0] <= 2)));
        chk(eff, e);
        chk(cap_sel, e > 2 ? 3'h2 : e);
        chk(amp_sel, e > 2 ? e - 3'h2 : 3'h0);
      end
    $display("gain test done");
    chk(ref_sel, `REF_INTERNAL);
    for (i = 1; i < 5; i = i + 1) begin
      @(posedge clock);
      rsrc <= i[1:0];
      ref_load <= 1'b1;
      @(posedge clock);
      ref_load <= 1'b0;
      #1;
      e = (i[1:0] == 2'h3) ? 3'h2 : {1'b0, i[1:0]};
      chk(ref_sel, e);
      chk(ext_buf, e == 3'h1);
    end
    chk(settling, 1);
    repeat (14) @(posedge clock);
    #1;
    chk(settling, 0);
    $display("reference test done");
    rate(0, 16 * `MOD_DIV * (`CLK_HZ / 1000) / (`OSC_NORMAL_HZ / 1000));
    restart(1);
    @(posedge clock);
    #1;
    chk(ovr, 0);
    while (!ovr) @(posedge clock);
    chk(ovr, 1);
    rdy <= 1'b1;
    n = 0;
    // eight buffered words plus the one held while the buffer was full
    while (n < 9) begin
      #1;
      if (s_valid) begin
        chk(s_data, DECIM);
        n = n + 1;
      end
      @(posedge clock);
      if (n == 9) rdy <= 1'b0;
    end
    #1;
    chk(s_valid, 0);
    $display("stream test done");
    rate(1, 16 * `MOD_DIV * (`CLK_HZ / 1000) / (`OSC_FAST_HZ / 1000));
    end_of_test;
  end
endmodule
